/* ccs_consts.vh */
// constants of the cpu clock generation and selection block
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH
// wishbone register byte addresses
`define CCS_ADR_CTRL 8'h00
`define CCS_ADR_STAT 8'h04
`define CCS_ADR_MASK 8'h08
`define CCS_ADR_INFO 8'h0C
// control register fields
`define CCS_CTRL_WDIS 4
`define CCS_CTRL_RST 8'h00
// status and mask fields
`define CCS_ST_OWD 0
`define CCS_ST_UNLOCK 1
`define CCS_ST_W 2
`define CCS_ST_RST 2'h0
// info register field positions
`define CCS_INFO_MODE_LO 0
`define CCS_INFO_SRC_LO 3
`define CCS_INFO_PLLFREE 6
`define CCS_INFO_WD_ON 7
// strap codes
`define CCS_MODE_X4 3'h7
`define CCS_MODE_X3 3'h6
`define CCS_MODE_X8 3'h5
`define CCS_MODE_X5 3'h4
`define CCS_MODE_DIRECT 3'h3
`define CCS_MODE_X10 3'h2
`define CCS_MODE_PRESC 3'h1
`define CCS_MODE_X16 3'h0
// multiplication factors
`define CCS_F3 5'h03
`define CCS_F4 5'h04
`define CCS_F5 5'h05
`define CCS_F8 5'h08
`define CCS_F10 5'h0A
`define CCS_F16 5'h10
`define CCS_F1 5'h01
// watchdog overflow after this many free-running cycles
`define CCS_WD_LIMIT 5'h10
`define CCS_WD_ZERO 5'h00
// misc widths and zero values
`define CCS_CNT_W 16
`define CCS_CNT_ZERO 16'h0000
`define CCS_CNT_ONE 16'h0001
`define CCS_BYTE_ZERO 8'h00
`define CCS_WORD_ZERO 32'h0000_0000
`endif

/* ccs_clock_select.v */
// cpu clock source selection, pll model, oscillator watchdog and register slave
// Summary of operation
// - strap pins latched while reset active; choice held until next reset
// - strap code maps to x4,x3,x8,x5,direct,x10,div2,x16
// - code 001 gives cpu clock as input divided by two
// - prescaler: each high and low phase lasts one input period
// - code 011 stops pll multiplication (pll stays powered while watchdog on), bypasses amplifier, drives cpu clock from input pin
// - direct drive: two consecutive half-periods equal one input period
// - watchdog enabled after reset; control bit 4 set disables it
// - watchdog works only in direct drive and prescaler modes
// - enabled watchdog: free pll counts, every input transition clears counter
// - sixteen free-running cycles without input transition mean clock failure
// - on failure switch cpu clock to free clock and flag interrupt
// - backup clock kept until reset even if input clock returns
// - watchdog disabled: cpu clock from oscillator, pll powered off
// - other codes enable pll; cpu clock is input times factor
// - pll resyncs every factor-count input transitions, adjusting gradually
// - both cpu clock edges usable; half-period is the timing unit
// - pll unlock raises interrupt and free-runs until reset
`timescale 1ns/1ps
`include "ccs_consts.vh"
module ccs_clock_select #(
  parameter FREE_DIV = 4,
  parameter LOCK_TIMEOUT = 1024
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [2:0] clock_strap_pins_i,
  input wire crystal_input_pin_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg cpu_clk_o,
  output wire pll_enable_o,
  output wire osc_bypass_o,
  output wire backup_active_o,
  output wire irq_o
);
  // clock source states
  localparam SRC_EXT = 3'b001;
  localparam SRC_SWITCH = 3'b010;
  localparam SRC_BACKUP = 3'b100;

  function [4:0] mult_factor;
    input [2:0] code;
    begin
      case (code)
        `CCS_MODE_X4: mult_factor = `CCS_F4;
        `CCS_MODE_X3: mult_factor = `CCS_F3;
        `CCS_MODE_X8: mult_factor = `CCS_F8;
        `CCS_MODE_X5: mult_factor = `CCS_F5;
        `CCS_MODE_X10: mult_factor = `CCS_F10;
        `CCS_MODE_X16: mult_factor = `CCS_F16;
        default: mult_factor = `CCS_F1;
      endcase
    end
  endfunction

  // pin synchronisers: first stage read only by second
  reg [2:0] strap_s1_q;
  reg [2:0] strap_s2_q;
  reg xtal_s1_q;
  reg xtal_s2_q;
  reg xtal_s3_q;
  always @(posedge ref_clk_i) begin
    strap_s1_q <= clock_strap_pins_i;
    strap_s2_q <= strap_s1_q;
    xtal_s1_q <= crystal_input_pin_i;
    xtal_s2_q <= xtal_s1_q;
    xtal_s3_q <= xtal_s2_q;
  end
  wire xtal_rise = xtal_s2_q & ~xtal_s3_q;
  wire xtal_edge = xtal_s2_q ^ xtal_s3_q;

  // strap latch: follows the pins during reset, frozen after release
  reg [2:0] mode_q;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= strap_s2_q;
    end
  end
  wire mode_direct = (mode_q == `CCS_MODE_DIRECT);
  wire mode_presc = (mode_q == `CCS_MODE_PRESC);
  wire mode_nopll = mode_direct | mode_presc;
  wire [4:0] factor = mult_factor(mode_q);

  // control and interrupt registers
  reg [7:0] ctrl_q;
  reg [1:0] stat_q;
  reg [1:0] stat_d;
  reg [1:0] mask_q;
  wire wd_disable = ctrl_q[`CCS_CTRL_WDIS];
  wire wd_on = ~wd_disable & mode_nopll;

  // free-running pll model: runs whenever the pll is powered
  reg [2:0] src_q;
  reg pll_free_q;
  wire pll_powered = ~mode_nopll | wd_on | (src_q != SRC_EXT);
  reg [`CCS_CNT_W-1:0] free_cnt_q;
  reg free_clk_q;
  wire free_tick = pll_powered & (free_cnt_q == FREE_DIV[`CCS_CNT_W-1:0] - `CCS_CNT_ONE);
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      free_cnt_q <= `CCS_CNT_ZERO;
      free_clk_q <= 1'b0;
    end else if (!pll_powered) begin
      free_cnt_q <= `CCS_CNT_ZERO;
      free_clk_q <= 1'b0;
    end else if (free_tick) begin
      free_cnt_q <= `CCS_CNT_ZERO;
      free_clk_q <= ~free_clk_q;
    end else begin
      free_cnt_q <= free_cnt_q + `CCS_CNT_ONE;
    end
  end
  wire free_rise = free_tick & ~free_clk_q;
  wire free_fall = free_tick & free_clk_q;

  // oscillator watchdog counter
  reg [4:0] wd_cnt_q;
  reg owd_fail;
  always @* begin
    owd_fail = wd_on & (src_q == SRC_EXT) & free_rise & ~xtal_edge &
      (wd_cnt_q == `CCS_WD_LIMIT - 5'h01);
  end
  always @(posedge ref_clk_i) begin
    if (rst_i || !wd_on) begin
      wd_cnt_q <= `CCS_WD_ZERO;
    end else if (xtal_edge) begin
      wd_cnt_q <= `CCS_WD_ZERO;
    end else if (free_rise && wd_cnt_q != `CCS_WD_LIMIT) begin
      wd_cnt_q <= wd_cnt_q + 5'h01;
    end
  end

  // source state: backup is sticky until reset
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      src_q <= SRC_EXT;
    end else begin
      case (src_q)
        SRC_EXT: begin
          if (owd_fail) begin
            src_q <= SRC_SWITCH;
          end
        end
        SRC_SWITCH: begin
          // waiting for the free clock to fall keeps the old phase long, never short
          if (free_fall) begin
            src_q <= SRC_BACKUP;
          end
        end
        SRC_BACKUP: begin
          src_q <= SRC_BACKUP;
        end
        default: begin
          src_q <= SRC_EXT;
        end
      endcase
    end
  end

  // prescaler: toggle on each input rising edge
  reg presc_q;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      presc_q <= 1'b0;
    end else if (xtal_rise) begin
      presc_q <= ~presc_q;
    end
  end

  // pll multiply model: measure the input period, run half-periods of period/(2F)
  reg [`CCS_CNT_W-1:0] per_cnt_q;
  reg [`CCS_CNT_W-1:0] period_q;
  reg [`CCS_CNT_W-1:0] half_q;
  reg [`CCS_CNT_W-1:0] half_tgt;
  reg [`CCS_CNT_W-1:0] ph_cnt_q;
  reg [4:0] sync_cnt_q;
  reg pll_clk_q;
  wire pll_run = ~mode_nopll & ~pll_free_q;
  wire lock_lost = pll_run & (per_cnt_q == LOCK_TIMEOUT[`CCS_CNT_W-1:0]);
  wire resync = pll_run & xtal_edge & (sync_cnt_q == factor - 5'h01);
  always @* begin
    half_tgt = period_q / {{(`CCS_CNT_W-6){1'b0}}, factor, 1'b0};
    if (half_tgt == `CCS_CNT_ZERO) begin
      half_tgt = `CCS_CNT_ONE;
    end
  end
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      per_cnt_q <= `CCS_CNT_ZERO;
      period_q <= `CCS_CNT_ZERO;
      half_q <= `CCS_CNT_ONE;
      ph_cnt_q <= `CCS_CNT_ZERO;
      sync_cnt_q <= `CCS_WD_ZERO;
      pll_clk_q <= 1'b0;
      pll_free_q <= 1'b0;
    end else begin
      if (xtal_rise) begin
        period_q <= per_cnt_q;
        per_cnt_q <= `CCS_CNT_ZERO;
      end else if (per_cnt_q != LOCK_TIMEOUT[`CCS_CNT_W-1:0]) begin
        per_cnt_q <= per_cnt_q + `CCS_CNT_ONE;
      end
      if (lock_lost) begin
        pll_free_q <= 1'b1;
      end
      if (xtal_edge) begin
        sync_cnt_q <= resync ? `CCS_WD_ZERO : sync_cnt_q + 5'h01;
      end
      if (resync) begin
        // one count per resync keeps the frequency from stepping abruptly
        if (half_q < half_tgt) begin
          half_q <= half_q + `CCS_CNT_ONE;
        end else if (half_q > half_tgt) begin
          half_q <= half_q - `CCS_CNT_ONE;
        end
      end
      if (ph_cnt_q >= half_q - `CCS_CNT_ONE) begin
        ph_cnt_q <= `CCS_CNT_ZERO;
        pll_clk_q <= ~pll_clk_q;
      end else begin
        ph_cnt_q <= ph_cnt_q + `CCS_CNT_ONE;
      end
    end
  end

  // cpu clock mux
  reg cpu_clk_d;
  always @* begin
    cpu_clk_d = cpu_clk_o;
    if (mode_nopll) begin
      case (src_q)
        SRC_EXT: cpu_clk_d = mode_presc ? presc_q : xtal_s2_q;
        SRC_SWITCH: cpu_clk_d = free_fall ? 1'b0 : cpu_clk_o;
        SRC_BACKUP: cpu_clk_d = free_clk_q;
        default: cpu_clk_d = 1'b0;
      endcase
    end else if (pll_free_q) begin
      cpu_clk_d = free_clk_q;
    end else begin
      cpu_clk_d = pll_clk_q;
    end
  end
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      cpu_clk_o <= 1'b0;
    end else begin
      cpu_clk_o <= cpu_clk_d;
    end
  end

  assign pll_enable_o = pll_powered;
  assign osc_bypass_o = mode_direct;
  assign backup_active_o = (src_q == SRC_BACKUP) | pll_free_q;

  // wishbone classic slave: ack one cycle after the request, write at the ack edge
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_now = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire [1:0] stat_set = {lock_lost, owd_fail};
  always @* begin
    stat_d = stat_q;
    if (wr_now && wb_adr_i == `CCS_ADR_STAT) begin
      stat_d = stat_q & ~wb_dat_i[`CCS_ST_W-1:0];
    end
    // an event in the clearing cycle is kept
    stat_d = stat_d | stat_set;
  end
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q <= `CCS_CTRL_RST;
      stat_q <= `CCS_ST_RST;
      mask_q <= `CCS_ST_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= `CCS_WORD_ZERO;
    end else begin
      stat_q <= stat_d;
      wb_ack_o <= req & ~wb_ack_o;
      if (wr_now) begin
        if (wb_adr_i == `CCS_ADR_CTRL) begin
          ctrl_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == `CCS_ADR_MASK) begin
          mask_q <= wb_dat_i[`CCS_ST_W-1:0];
        end
      end
      if (req && !wb_ack_o) begin
        if (wb_adr_i == `CCS_ADR_CTRL) begin
          wb_dat_o <= {24'h00_0000, ctrl_q};
        end else if (wb_adr_i == `CCS_ADR_STAT) begin
          wb_dat_o <= {30'h0000_0000, stat_q};
        end else if (wb_adr_i == `CCS_ADR_MASK) begin
          wb_dat_o <= {30'h0000_0000, mask_q};
        end else if (wb_adr_i == `CCS_ADR_INFO) begin
          wb_dat_o <= {24'h00_0000, wd_on, pll_free_q, src_q, mode_q};
        end else begin
          wb_dat_o <= `CCS_WORD_ZERO;
        end
      end
    end
  end
  assign irq_o = |(stat_q & mask_q);
endmodule

/* ccs_clock_select_sva.sv */
// assertions on the ports of the cpu clock selection block
`timescale 1ns/1ps
`include "ccs_consts.vh"
module ccs_clock_select_sva (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [2:0] clock_strap_pins_i,
  input wire crystal_input_pin_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire cpu_clk_o,
  input wire pll_enable_o,
  input wire osc_bypass_o,
  input wire backup_active_o,
  input wire irq_o
);
  reg [2:0] mode_q;
  reg wdis_q;
  wire pll_mode = mode_q != `CCS_MODE_DIRECT && mode_q != `CCS_MODE_PRESC;
  // own copy of strap and disable bit, so a stuck design register is seen
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= clock_strap_pins_i;
      wdis_q <= 1'b0;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `CCS_ADR_CTRL) begin
      wdis_q <= wb_dat_i[`CCS_CTRL_WDIS];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_bypass_code: assert property (osc_bypass_o == (mode_q == `CCS_MODE_DIRECT))
    else $error("bypass does not match strap");
  chk_pll_on: assert property (pll_mode |-> pll_enable_o)
    else $error("pll off in multiply mode");
  chk_pll_off: assert property (!pll_mode && wdis_q && !backup_active_o |-> !pll_enable_o)
    else $error("pll on with watch disabled");
  chk_backup_kept: assert property (backup_active_o |=> backup_active_o)
    else $error("backup clock left");
  chk_direct_follow: assert property (osc_bypass_o && !backup_active_o && !$past(rst_i, 4)
    && $rose(crystal_input_pin_i) |-> ##[2:4] cpu_clk_o) else $error("cpu clock not following");
  chk_presc_toggle: assert property (mode_q == `CCS_MODE_PRESC && !backup_active_o
    && !$past(rst_i, 4) && $rose(crystal_input_pin_i) |-> ##[2:4] $changed(cpu_clk_o))
    else $error("prescaler missed a toggle");
  chk_irq_clear: assert property ($fell(irq_o) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("irq dropped without write");
endmodule
bind ccs_clock_select ccs_clock_select_sva chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .clock_strap_pins_i(clock_strap_pins_i), .crystal_input_pin_i(crystal_input_pin_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cpu_clk_o(cpu_clk_o), .pll_enable_o(pll_enable_o), .osc_bypass_o(osc_bypass_o),
  .backup_active_o(backup_active_o), .irq_o(irq_o));

/* ccs_xtal_src.sv */
// crystal source model that can run at a set rate or stop
`timescale 1ns/1ps
module ccs_xtal_src (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [3:0] half_i,
  output logic xtal_o
);
  logic [3:0] cnt_q;
  initial begin
    xtal_o = 1'b0;
    cnt_q = 4'h1;
  end
  // a dead oscillator freezes at its last level, the case the watch unit must catch
  always @(posedge clk_i) begin
    if (run_i && cnt_q >= half_i) begin
      xtal_o <= ~xtal_o;
      cnt_q <= 4'h1;
    end else if (run_i) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

/* test_cpu_clock_generation_select.sv */
// self-checking testbench of the cpu clock selection block
`timescale 1ns/1ps
`include "ccs_consts.vh"
module test_cpu_clock_generation_select;
  logic clk, rst, cyc, stb, we, ack, cpu, pll_en, byp, bkp, irq, xtal, run, win, msk, xt_l, cpu_l;
  logic [2:0] strap, c, win_d;
  logic [3:0] half, sel;
  logic [7:0] adr;
  logic [15:0] lfsr;
  logic [31:0] wdat, rdat, q;
  int error_cnt, n_checks, cpu_n, xt_n, xt_r;
  ccs_clock_select #(.LOCK_TIMEOUT(64)) dut_u (.ref_clk_i(clk), .rst_i(rst),
    .clock_strap_pins_i(strap), .crystal_input_pin_i(xtal), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cpu_clk_o(cpu), .pll_enable_o(pll_en), .osc_bypass_o(byp),
    .backup_active_o(bkp), .irq_o(irq));
  ccs_xtal_src src_u (.clk_i(clk), .run_i(run), .half_i(half), .xtal_o(xtal));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic wd_mode(input logic [2:0] m);
    return m == `CCS_MODE_DIRECT || m == `CCS_MODE_PRESC;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wb(input logic w, input logic [3:0] s, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= s;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    if (n >= 40) chk(0, 1);
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    xt_l <= xtal;
    cpu_l <= cpu;
    win_d <= {win_d[1:0], win};
    if (win && xtal != xt_l) xt_n++;
    if (win && xtal && !xt_l) xt_r++;
    // cpu side counted later to cover the synchroniser latency
    if (win_d[2] && cpu != cpu_l) cpu_n++;
  end
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    {rst, cyc, stb, we, win, run, adr, wdat, win_d} = 1;
    sel = 4'hF;
    strap = 3'h7;
    half = 4'h5;
    lfsr = 16'hE761;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      rst <= 1;
      strap <= c;
      run <= 0;
      repeat (8) @(posedge clk);
      rst <= 0;
      half <= 4'h5 + {2'b00, lfsr[1:0]};
      lfsr = lfsr_next(lfsr);
      run <= 1;
      @(posedge clk);
      wb(0, 4'hF, `CCS_ADR_INFO, 0);
      chk(q, {24'h0, wd_mode(c), 4'b0001, c});
      chk(byp, c == `CCS_MODE_DIRECT);
      chk(pll_en, 1);
      wb(1, 4'hF, 8'h40 + {lfsr[3:0], 2'b00}, {16'h0, lfsr});
      wb(0, 4'hF, 8'h40 + {lfsr[3:0], 2'b00}, 0);
      chk(q, 0);
      {cpu_n, xt_n, xt_r} = 0;
      @(xtal);
      repeat (2) @(posedge clk);
      win <= 1;
      repeat (10 * half) @(posedge clk);
      win <= 0;
      repeat (6) @(posedge clk);
      if (wd_mode(c)) chk(cpu_n, c == `CCS_MODE_DIRECT ? xt_n : xt_r);
      // multiplied clock: at least two cpu edges per crystal edge for every factor
      if (!wd_mode(c)) chk(cpu_n >= 2 * xt_n && xt_n > 0, 1);
      if (c == `CCS_MODE_DIRECT) begin
        wb(1, 4'hE, `CCS_ADR_CTRL, 32'h10);
        wb(0, 4'hF, `CCS_ADR_CTRL, 0);
        chk(q, 0);
        wb(1, 4'hF, `CCS_ADR_CTRL, 32'h10);
        chk(pll_en, 0);
        run <= 0;
        repeat (200) @(posedge clk);
        chk(bkp, 0);
        run <= 1;
        wb(1, 4'hF, `CCS_ADR_CTRL, 0);
        chk(pll_en, 1);
      end
      msk = c != `CCS_MODE_DIRECT;
      wb(1, 4'hF, `CCS_ADR_MASK, {30'h0, msk, msk});
      run <= 0;
      repeat (90) @(posedge clk);
      if (wd_mode(c)) chk(bkp, 0);
      repeat (110) @(posedge clk);
      wb(0, 4'hF, `CCS_ADR_STAT, 0);
      chk(q, wd_mode(c) ? 1 : 2);
      chk(bkp, 1);
      chk(irq, msk);
      run <= 1;
      repeat (60) @(posedge clk);
      chk(bkp, 1);
      wb(1, 4'hF, `CCS_ADR_MASK, 3);
      chk(irq, 1);
      wb(1, 4'hF, `CCS_ADR_STAT, 3);
      chk(irq, 0);
    end
    wrap_up;
  end
endmodule
